// ---- logic/spm_pkg.sv ----
// Package for the serial master engine: control bit positions, reset value, states
package spm_pkg;
    localparam int CTL_DONE_POS = 7;
    localparam int CTL_MEN_POS = 6;
    localparam int CTL_FAULT_POS = 5;
    localparam int CTL_SMHI_POS = 3;
    localparam int CTL_SMLO_POS = 2;
    localparam int CTL_IEN_POS = 0;
    localparam logic [7:0] CTL_RESET = 8'h04;
    localparam logic [3:0] BITS_PER_XFER = 4'h8;
    localparam int SCK_HALF_NS = 32;
    localparam int CLK_NS = 8;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        SPM_IDLE = 2'b00,
        SPM_LEAD = 2'b01,
        SPM_TRAIL = 2'b10
    } spm_state_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic ss_out;
        logic ss_oe;
    } spm_pins_t;
endpackage

// ---- logic/spm_engine.sv ----
// Serial master engine with transmit and receive buffers and select modes
//
// How it works
// - Engine acts as bus master while master enable and IEN control bits are both set.
// - Data write fills transmit buffer; moves to empty shifter, starting transfer.
// - During a transfer, bits shift out on MOSI with SCK generated.
// - Transfer done flag sets when the eighth bit's trailing tick arrives, even on an abort in that cycle; earlier aborts leave it unchanged.
// - Done flag with interrupts enabled raises interrupt request.
// - Received bits enter MSB first; full byte moves to receive buffer.
// - Select mode hi 0, lo 1 gives multi-master; select pin is input.
// - Low select input in multi-master clears enables, sets mode fault.
// - Mode fault interrupts if enabled; stays disabled until software re-enables.
// - Both select bits zero: select pin ignored and not driven.
// - Select mode hi one: select pin driven from select mode lo.
// - Clock polarity bit one inverts the SCK waveform.
`timescale 1ns/1ps
`default_nettype none
module spm_engine
    import spm_pkg::*;
#(
    parameter int HALF_CYC = SCK_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctl_wr,
    input wire logic [7:0] ctl_wdata,
    output logic [7:0] ctl_rdata,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    output logic [7:0] data_rdata,
    input wire logic clock_polarity_bit,
    input wire logic clock_phase_bit,
    input wire logic int_enable,
    output logic irq,
    output logic tx_buf_full,
    input wire logic miso,
    input wire logic slave_select_pin,
    output spm_pins_t pins
);

    initial begin
        if (HALF_CYC < 1 || HALF_CYC > 255) begin
            $error("HALF_CYC out of range");
        end
    end

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [2:0] miso_sync_reg;
    logic [2:0] ss_sync_reg;
    logic ss_in_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            miso_sync_reg <= 3'h7;
            ss_sync_reg <= 3'h7;
            ss_in_reg <= 1'b1;
        end else begin
            miso_sync_reg <= {miso_sync_reg[1:0], miso};
            ss_sync_reg <= {ss_sync_reg[1:0], slave_select_pin};
            if (ss_sync_reg[1] == ss_sync_reg[2]) begin
                ss_in_reg <= ss_sync_reg[2];
            end
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [7:0] ctl_reg;
    logic multi_mode;
    logic fault_hit;
    logic xfer_end;
    assign multi_mode = !ctl_reg[CTL_SMHI_POS] && ctl_reg[CTL_SMLO_POS];
    assign fault_hit = multi_mode && !ss_in_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg <= CTL_RESET;
        end else begin
            if (ctl_wr) begin
                ctl_reg <= ctl_wdata;
            end
            if (fault_hit) begin
                ctl_reg[CTL_MEN_POS] <= 1'b0;
                ctl_reg[CTL_IEN_POS] <= 1'b0;
                ctl_reg[CTL_FAULT_POS] <= 1'b1;
            end
            if (xfer_end) begin
                ctl_reg[CTL_DONE_POS] <= 1'b1;
            end
        end
    end
    assign ctl_rdata = ctl_reg;

    logic master_on;
    assign master_on = ctl_reg[CTL_MEN_POS] && ctl_reg[CTL_IEN_POS];

    // Interrupt from done or fault
    assign irq = int_enable && (ctl_reg[CTL_DONE_POS] || ctl_reg[CTL_FAULT_POS]);

    // ----------------------------------------
    // Transmit buffer
    // ----------------------------------------
    logic [7:0] tx_buf_reg;
    logic tx_full_reg;
    logic load;
    spm_state_t state_reg;
    assign load = tx_full_reg && state_reg == SPM_IDLE && master_on;
    assign tx_buf_full = tx_full_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_buf_reg <= 8'h00;
            tx_full_reg <= 1'b0;
        end else begin
            if (data_wr) begin
                tx_buf_reg <= data_wdata;
                tx_full_reg <= 1'b1;
            end else if (load) begin
                tx_full_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Shift engine
    // ----------------------------------------
    logic [7:0] shift_reg;
    logic [7:0] rx_buf_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] div_reg;
    logic phase_tick;
    logic sck_reg;
    logic mosi_reg;
    assign phase_tick = div_reg == 8'(HALF_CYC - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 8'h00;
        end else if (state_reg == SPM_IDLE || phase_tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    assign xfer_end = state_reg == SPM_TRAIL && phase_tick && bit_cnt_reg == BITS_PER_XFER;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SPM_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            sck_reg <= 1'b0;
            mosi_reg <= 1'b0;
            rx_buf_reg <= 8'h00;
        end else begin
            case (state_reg)
                SPM_IDLE: begin
                    sck_reg <= 1'b0;
                    if (load) begin
                        shift_reg <= tx_buf_reg;
                        bit_cnt_reg <= 4'h0;
                        mosi_reg <= tx_buf_reg[7];
                        state_reg <= SPM_LEAD;
                    end
                end
                SPM_LEAD: begin
                    if (!master_on) begin
                        sck_reg <= 1'b0;
                        state_reg <= SPM_IDLE;
                    end else if (phase_tick) begin
                        sck_reg <= 1'b1;
                        if (!clock_phase_bit) begin
                            shift_reg <= {shift_reg[6:0], miso_sync_reg[2]};
                        end else begin
                            mosi_reg <= shift_reg[7];
                        end
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        state_reg <= SPM_TRAIL;
                    end
                end
                SPM_TRAIL: begin
                    if (!master_on) begin
                        sck_reg <= 1'b0;
                        state_reg <= SPM_IDLE;
                    end else if (phase_tick) begin
                        sck_reg <= 1'b0;
                        if (clock_phase_bit) begin
                            shift_reg <= {shift_reg[6:0], miso_sync_reg[2]};
                        end else begin
                            mosi_reg <= shift_reg[7];
                        end
                        if (bit_cnt_reg == BITS_PER_XFER) begin
                            rx_buf_reg <= clock_phase_bit ?
                                {shift_reg[6:0], miso_sync_reg[2]} : shift_reg;
                            state_reg <= SPM_IDLE;
                        end else begin
                            state_reg <= SPM_LEAD;
                        end
                    end
                end
                default: begin
                    state_reg <= SPM_IDLE;
                end
            endcase
        end
    end
    assign data_rdata = rx_buf_reg;

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    always_comb begin
        pins.sck = sck_reg ^ clock_polarity_bit;
        pins.mosi = mosi_reg;
        pins.ss_oe = ctl_reg[CTL_SMHI_POS];
        pins.ss_out = ctl_reg[CTL_SMHI_POS] && ctl_reg[CTL_SMLO_POS];
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_fault_clears_en: assert property (@(posedge clk) disable iff (!rst_n)
        fault_hit |=> !ctl_reg[CTL_MEN_POS] && ctl_reg[CTL_FAULT_POS])
        else $error("mode fault did not disable master");
    a_done_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
        xfer_end |=> ctl_reg[CTL_DONE_POS])
        else $error("done flag not set");
    a_irq_on_done: assert property (@(posedge clk) disable iff (!rst_n)
        int_enable && ctl_reg[CTL_DONE_POS] |-> irq)
        else $error("irq missing");
    a_load_starts: assert property (@(posedge clk) disable iff (!rst_n)
        load |=> state_reg == SPM_LEAD && shift_reg == $past(tx_buf_reg))
        else $error("load did not start transfer");
    a_idle_no_master: assert property (@(posedge clk) disable iff (!rst_n)
        !master_on && state_reg == SPM_IDLE |=> state_reg == SPM_IDLE)
        else $error("transfer without master enable");
    a_ss_drive_mode: assert property (@(posedge clk) disable iff (!rst_n)
        ctl_reg[CTL_SMHI_POS] |-> pins.ss_oe && pins.ss_out == ctl_reg[CTL_SMLO_POS])
        else $error("select output wrong");
    a_ss_quiet_3w: assert property (@(posedge clk) disable iff (!rst_n)
        !ctl_reg[CTL_SMHI_POS] && !ctl_reg[CTL_SMLO_POS] |-> !pins.ss_oe && !fault_hit)
        else $error("select used in 3-wire mode");
    a_sck_polarity: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == SPM_IDLE |-> pins.sck == clock_polarity_bit)
        else $error("idle sck polarity wrong");
    a_eight_bits: assert property (@(posedge clk) disable iff (!rst_n)
        xfer_end |-> bit_cnt_reg == 4'h8)
        else $error("transfer length not eight");
    a_sck_toggles: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == SPM_LEAD && phase_tick && master_on |=> sck_reg)
        else $error("sck did not rise");
    a_sck_falls: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == SPM_TRAIL && phase_tick && master_on |=> !sck_reg)
        else $error("sck did not fall");
    a_irq_on_fault: assert property (@(posedge clk) disable iff (!rst_n)
        int_enable && ctl_reg[CTL_FAULT_POS] |-> irq)
        else $error("irq missing on mode fault");
    a_fault_stays_off: assert property (@(posedge clk) disable iff (!rst_n)
        ctl_reg[CTL_FAULT_POS] && !master_on && !ctl_wr |=> !master_on)
        else $error("master re-enabled without software");
    a_done_holds: assert property (@(posedge clk) disable iff (!rst_n)
        ctl_reg[CTL_DONE_POS] && !ctl_wr |=> ctl_reg[CTL_DONE_POS])
        else $error("done flag cleared by hardware");
    a_rx_on_end: assert property (@(posedge clk) disable iff (!rst_n)
        xfer_end && !clock_phase_bit |=> data_rdata == $past(shift_reg))
        else $error("receive buffer not updated");
    a_abort_idle: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg != SPM_IDLE && !master_on |=> state_reg == SPM_IDLE && !sck_reg)
        else $error("abort did not return to idle");
    a_idle_no_start: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == SPM_IDLE && !load |=> state_reg == SPM_IDLE)
        else $error("transfer started without load");
    a_load_clears_full: assert property (@(posedge clk) disable iff (!rst_n)
        load && !data_wr |=> !tx_buf_full)
        else $error("buffer still full after load");
    a_mosi_first_bit: assert property (@(posedge clk) disable iff (!rst_n)
        load |=> pins.mosi == $past(tx_buf_reg[7]))
        else $error("first bit not msb");
    a_cnt_bound: assert property (@(posedge clk) disable iff (!rst_n)
        bit_cnt_reg <= BITS_PER_XFER)
        else $error("bit count overrun");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    c_transfer_done: cover property (@(posedge clk) disable iff (!rst_n) xfer_end);
    c_three_wire: cover property (@(posedge clk) disable iff (!rst_n)
        !ctl_reg[CTL_SMHI_POS] && !ctl_reg[CTL_SMLO_POS] && master_on);
    c_four_wire: cover property (@(posedge clk) disable iff (!rst_n)
        ctl_reg[CTL_SMHI_POS] && master_on);
    c_mode_fault: cover property (@(posedge clk) disable iff (!rst_n) fault_hit);
    c_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
        xfer_end ##1 load);

endmodule
`default_nettype wire

// ---- dv/spm_slave_model.sv ----
// Behavioural serial slave model for the master engine bench
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic load,
    input wire logic [7:0] load_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] tx = 8'h00;
    initial miso = 1'b1;
    always @(posedge load) begin
        tx = load_byte;
        miso = load_byte[7];
        rx_byte = 8'h00;
    end
    // Capture and shift on opposite edges, full duplex
    always @(sck) begin
        if ((sck != cpol) ^ cpha) begin
            rx_byte = {rx_byte[6:0], mosi};
        end else begin
            if (!cpha)
                tx = {tx[6:0], ~tx[7]};
            miso = tx[7];
            if (cpha)
                tx = {tx[6:0], ~tx[7]};
        end
    end
endmodule
`default_nettype wire

// ---- dv/spm_engine_tb.sv ----
// Self-checking bench for the serial master engine
`timescale 1ns/1ps
`default_nettype none
module spm_engine_tb;
    import spm_pkg::*;
    logic clk, rst_n, ctl_wr, data_wr, cpol, cpha, int_en, miso, ss, load, irq, tx_full;
    logic [7:0] ctl_wdata, data_wdata, ctl_rdata, data_rdata, sbyte, srx;
    spm_pins_t pins;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;

    spm_engine DUT (.clk(clk), .rst_n(rst_n), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
        .ctl_rdata(ctl_rdata), .data_wr(data_wr), .data_wdata(data_wdata),
        .data_rdata(data_rdata), .clock_polarity_bit(cpol), .clock_phase_bit(cpha),
        .int_enable(int_en), .irq(irq), .tx_buf_full(tx_full), .miso(miso),
        .slave_select_pin(ss), .pins(pins));
    spm_slave_model SLV (.sck(pins.sck), .mosi(pins.mosi), .cpol(cpol), .cpha(cpha),
        .load(load), .load_byte(sbyte), .miso(miso), .rx_byte(srx));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report;
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic ctl(input logic [7:0] v);
        ctl_wdata = v;
        ctl_wr = 1'b1;
        @(negedge clk);
        ctl_wr = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic dwr(input logic [7:0] v);
        data_wdata = v;
        data_wr = 1'b1;
        @(negedge clk);
        data_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic slv(input logic [7:0] s);
        sbyte = s;
        load = 1'b1;
        @(negedge clk);
        load = 1'b0;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (ctl_rdata[7] !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        chk({7'h00, ctl_rdata[7]}, 8'h01);
    endtask
    task automatic finish(input logic [7:0] m, input logic [7:0] s);
        wait_done();
        chk(data_rdata, s);
        chk(srx, m);
    endtask

    initial begin
        {ctl_wr, data_wr, cpol, cpha, int_en, load, rst_n} = 7'h00;
        {ctl_wdata, data_wdata, sbyte} = 24'h000000;
        ss = 1'b1;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(ctl_rdata, CTL_RESET);
        dwr(8'ha5);
        repeat (100) @(negedge clk);
        chk({5'h00, pins.sck, tx_full, ctl_rdata[7]}, 8'h02);
        slv(8'h3c);
        int_en = 1'b1;
        ctl(8'h45);
        finish(8'ha5, 8'h3c);
        chk({7'h00, irq}, 8'h01);
        chk(ctl_rdata, 8'hc5);
        ctl(8'h45);
        chk({7'h00, irq}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            cpol = i[1];
            cpha = i[0];
            repeat (2) @(negedge clk);
            chk({7'h00, pins.sck}, {7'h00, cpol});
            slv(8'h3a - 8'(i));
            dwr(8'hc1 + 8'(i));
            finish(8'hc1 + 8'(i), 8'h3a - 8'(i));
            ctl(8'h45);
        end
        dwr(8'h12);
        dwr(8'h9e);
        repeat (3) @(negedge clk);
        chk({7'h00, tx_full}, 8'h01);
        wait_done();
        ctl(8'h45);
        wait_done();
        chk(srx, 8'h9e);
        ctl(8'h4d);
        chk({6'h00, pins.ss_oe, pins.ss_out}, 8'h03);
        ctl(8'h49);
        chk({6'h00, pins.ss_oe, pins.ss_out}, 8'h02);
        ctl(8'h41);
        ss = 1'b0;
        repeat (8) @(negedge clk);
        chk({7'h00, pins.ss_oe}, 8'h00);
        chk(ctl_rdata, 8'h41);
        ss = 1'b1;
        repeat (6) @(negedge clk);
        ctl(8'h45);
        ss = 1'b0;
        repeat (8) @(negedge clk);
        chk(ctl_rdata, 8'h24);
        chk({7'h00, irq}, 8'h01);
        dwr(8'h77);
        repeat (100) @(negedge clk);
        chk({7'h00, ctl_rdata[7]}, 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
